/* File: rtl/optical_pulse_pkg.sv */
// constants, register map and control types for the optical port and pulse output block
package optical_pulse_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_PULSE_CFG = 16'h2004;
  localparam logic [15:0] IDX_TX_CFG = 16'h2007;
  localparam logic [15:0] IDX_OPT_CFG = 16'h2008;
  localparam logic [15:0] IDX_MAX_WIDTH = 16'h2080;
  localparam logic [15:0] IDX_INTERVAL = 16'h2081;
  localparam logic [15:0] IDX_STATUS = 16'h2082;
  // field positions
  localparam int POS_PULSE_INV = 6;
  localparam int POS_DUTY = 0;
  localparam int POS_TXSEL = 6;
  localparam int POS_TXINV = 0;
  localparam int POS_TXMOD = 1;
  localparam int POS_RXINV = 4;
  localparam int POS_RXDIS = 5;
  // reset values
  localparam logic [7:0] MAX_WIDTH_RST = 8'hFF;
  localparam logic [7:0] INTERVAL_RST = 8'h00;
  localparam logic [7:0] WIDTH_NO_LIMIT = 8'hFF;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SAMPLE_TIME_NS = 397000;
  localparam int SAMPLE_CYCLES = SAMPLE_TIME_NS / CLK_PERIOD_NS;
  localparam int INTERVAL_UNIT_NS = 1000;
  localparam int INTERVAL_UNIT_CYCLES = INTERVAL_UNIT_NS / CLK_PERIOD_NS;
  localparam int CARRIER_CYCLES_DEF = 512;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TX_UART = 2'b00,
    TX_DIO_TWO = 2'b01,
    TX_REAL = 2'b10,
    TX_REACTIVE = 2'b11
  } tx_source_type;

  typedef struct packed {
    logic pulse_polarity_invert;
    logic [1:0] tx_modulation_duty;
    tx_source_type tx_pin_source_select;
    logic tx_invert;
    logic tx_modulation_enable;
    logic rx_comparator_invert;
    logic rx_pin_digital_select;
    logic [7:0] pulse_max_width;
    logic [7:0] pulse_fifo_interval;
  } ctrl_type;

  localparam ctrl_type CTRL_RST = '{1'b0, 2'h0, TX_UART, 1'b0, 1'b0, 1'b0, 1'b0,
                                    MAX_WIDTH_RST, INTERVAL_RST};
endpackage

/* File: rtl/optical_pulse_port.sv */
// optical port pin conditioning and energy pulse shaping with an AXI4-Lite register slave
//
// Notes on behaviour
// - duty field sets carrier low fraction
// - rx disable bit routes pin to digital
// - rx invert flips comparator result for uart
// - two-bit select picks transmit pin source
// - tx invert flips the transmit signal
// - modulation replaces low intervals with carrier
// - modulation follows the optional inversion
// - pulse low width limited to 2N+1 units
// - interval zero means sample unit; max width 255 unlimited while interval is zero
// - interval zero bypasses fifo, pulses immediately
// - pulses active low unless invert bit set
`timescale 1ns/10ps
module optical_pulse_port
  import optical_pulse_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int SAMPLE_CYC = SAMPLE_CYCLES,
  parameter int CARRIER_CYCLES = CARRIER_CYCLES_DEF,
  parameter int PEND_W = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // receive pin, both views asynchronous
  input wire logic rx_comparator_in,
  input wire logic optical_receive_pin,
  output logic uart_rx,
  output logic general_digital_pin_one,
  // transmit sources on this clock
  input wire logic uart_tx,
  input wire logic general_digital_pin_two,
  input wire logic [1:0] energy_pulse_request,
  // pins
  output logic optical_transmit_pin,
  output logic real_energy_pulse,
  output logic reactive_energy_pulse
);
  localparam int CW = $clog2(CARRIER_CYCLES);

  initial begin
    if (ADDR_W < 18 || ADDR_W > 32) $error("ADDR_W must be 18..32");
    if (CARRIER_CYCLES < 16 || CARRIER_CYCLES % 16 != 0) $error("CARRIER_CYCLES bad");
    if (SAMPLE_CYC < 1 || SAMPLE_CYC > 65535) $error("SAMPLE_CYC out of range");
    if (PEND_W < 1 || PEND_W > 8) $error("PEND_W out of range");
  end

  ctrl_type ctrl;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic wlane_q;
  logic do_write;
  logic [15:0] widx;
  logic [15:0] ridx;
  logic [7:0] status;

  // write address and data are taken in either order, answered once both are held
  assign do_write = !awready && !wready && !bvalid;
  assign widx = waddr_q[17:2];
  assign ridx = araddr[17:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      waddr_q <= '0;
      wdata_q <= '0;
      wlane_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        waddr_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wlane_q <= wstrb[0];
        wready <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= (widx inside {IDX_PULSE_CFG, IDX_TX_CFG, IDX_OPT_CFG, IDX_MAX_WIDTH,
                               IDX_INTERVAL, IDX_STATUS}) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // control registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RST;
    end else if (do_write && wlane_q) begin
      unique case (widx)
        IDX_PULSE_CFG: ctrl.pulse_polarity_invert <= wdata_q[POS_PULSE_INV];
        IDX_TX_CFG: begin
          ctrl.tx_modulation_duty <= wdata_q[POS_DUTY +: 2];
          ctrl.tx_pin_source_select <= tx_source_type'(wdata_q[POS_TXSEL +: 2]);
        end
        IDX_OPT_CFG: begin
          ctrl.tx_invert <= wdata_q[POS_TXINV];
          ctrl.tx_modulation_enable <= wdata_q[POS_TXMOD];
          ctrl.rx_comparator_invert <= wdata_q[POS_RXINV];
          ctrl.rx_pin_digital_select <= wdata_q[POS_RXDIS];
        end
        IDX_MAX_WIDTH: ctrl.pulse_max_width <= wdata_q[7:0];
        IDX_INTERVAL: ctrl.pulse_fifo_interval <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= RESP_OKAY;
        rdata <= '0;
        unique case (ridx)
          IDX_PULSE_CFG: rdata[POS_PULSE_INV] <= ctrl.pulse_polarity_invert;
          IDX_TX_CFG: begin
            rdata[POS_DUTY +: 2] <= ctrl.tx_modulation_duty;
            rdata[POS_TXSEL +: 2] <= ctrl.tx_pin_source_select;
          end
          IDX_OPT_CFG: begin
            rdata[POS_TXINV] <= ctrl.tx_invert;
            rdata[POS_TXMOD] <= ctrl.tx_modulation_enable;
            rdata[POS_RXINV] <= ctrl.rx_comparator_invert;
            rdata[POS_RXDIS] <= ctrl.rx_pin_digital_select;
          end
          IDX_MAX_WIDTH: rdata[7:0] <= ctrl.pulse_max_width;
          IDX_INTERVAL: rdata[7:0] <= ctrl.pulse_fifo_interval;
          IDX_STATUS: rdata[7:0] <= status;
          default: rresp <= RESP_SLVERR;
        endcase
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // three-stage synchronisers; a new level counts once stages two and three agree
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync3;
  logic [1:0] rx_level;
  logic [1:0] rx_raw;
  assign rx_raw = {optical_receive_pin, rx_comparator_in};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync1[i] <= 1'b1;
        sync2[i] <= 1'b1;
        sync3[i] <= 1'b1;
        rx_level[i] <= 1'b1;
      end else begin
        sync1[i] <= rx_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) rx_level[i] <= sync3[i];
      end
    end
  end

  // receive routing; uart sees idle high while the pin serves as digital input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uart_rx <= 1'b1;
      general_digital_pin_one <= 1'b0;
    end else if (ctrl.rx_pin_digital_select) begin
      uart_rx <= 1'b1;
      general_digital_pin_one <= rx_level[1];
    end else begin
      uart_rx <= rx_level[0] ^ ctrl.rx_comparator_invert;
      general_digital_pin_one <= 1'b0;
    end
  end

  // time unit tick: sample time, or interval units while the fifo paces pulses
  logic [15:0] tick_cnt;
  logic [15:0] t1_len;
  logic tick;
  assign t1_len = (ctrl.pulse_fifo_interval == 8'h00) ? 16'(SAMPLE_CYC)
                : 16'(ctrl.pulse_fifo_interval * 16'(INTERVAL_UNIT_CYCLES));
  assign tick = (tick_cnt >= t1_len - 16'h0001);

  always_ff @(posedge aclk) begin
    if (!aresetn) tick_cnt <= '0;
    else tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
  end

  // pulse channels: 0 real energy, 1 reactive energy
  logic [1:0] req_prev;
  logic [1:0] active;
  logic [8:0] units [2];
  logic [PEND_W-1:0] pending [2];
  logic fifo_mode;
  logic limit_en;
  logic [8:0] limit;
  logic [8:0] fifo_len;
  assign fifo_mode = (ctrl.pulse_fifo_interval != 8'h00);
  assign limit_en = (ctrl.pulse_max_width != WIDTH_NO_LIMIT);
  assign limit = {ctrl.pulse_max_width, 1'b1};
  assign fifo_len = limit_en ? limit : 9'h001;

  for (genvar c = 0; c < 2; c++) begin : g_pulse
    logic rise;
    logic take;
    logic put;
    assign rise = energy_pulse_request[c] && !req_prev[c];
    assign put = fifo_mode && rise && (pending[c] != '1);
    assign take = fifo_mode && !active[c] && (pending[c] != '0) && tick;

    always_ff @(posedge aclk) begin
      if (!aresetn) req_prev[c] <= 1'b0;
      else req_prev[c] <= energy_pulse_request[c];
    end

    // queue depth; a request arriving with a release keeps its place unless the queue is already full
    always_ff @(posedge aclk) begin
      if (!aresetn || !fifo_mode) pending[c] <= '0;
      else pending[c] <= pending[c] + PEND_W'(put) - PEND_W'(take);
    end

    // pulse state and width in time units, limit ends the pulse early
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        active[c] <= 1'b0;
        units[c] <= '0;
      end else if (!active[c]) begin
        units[c] <= '0;
        if (fifo_mode ? take : rise) active[c] <= 1'b1;
      end else begin
        if (tick) units[c] <= units[c] + 9'h001;
        if (fifo_mode) begin
          if (tick && units[c] + 9'h001 >= fifo_len) active[c] <= 1'b0;
        end else if (!energy_pulse_request[c] ||
                     (limit_en && tick && units[c] + 9'h001 >= limit)) begin
          active[c] <= 1'b0;
        end
      end
    end
  end

  // pulse pins, active low unless inverted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      real_energy_pulse <= 1'b1;
      reactive_energy_pulse <= 1'b1;
    end else begin
      real_energy_pulse <= active[0] ~^ ctrl.pulse_polarity_invert;
      reactive_energy_pulse <= active[1] ~^ ctrl.pulse_polarity_invert;
    end
  end

  // carrier divider; fixed period keeps the low fraction exact for every duty code
  logic [CW-1:0] car_cnt;
  logic [CW-1:0] low_len;
  logic carrier_low;
  // three-bit shift amount, so code 11 shifts by four instead of wrapping to zero
  assign low_len = CW'(CARRIER_CYCLES >> (3'(ctrl.tx_modulation_duty) + 3'd1));
  assign carrier_low = (car_cnt < low_len);

  always_ff @(posedge aclk) begin
    if (!aresetn || car_cnt == CW'(CARRIER_CYCLES - 1)) car_cnt <= '0;
    else car_cnt <= car_cnt + 1'b1;
  end

  // transmit path: select, invert, then modulate the low intervals
  logic tx_sel;
  logic tx_pre;
  always_comb begin
    unique case (ctrl.tx_pin_source_select)
      TX_UART: tx_sel = uart_tx;
      TX_DIO_TWO: tx_sel = general_digital_pin_two;
      TX_REAL: tx_sel = real_energy_pulse;
      TX_REACTIVE: tx_sel = reactive_energy_pulse;
    endcase
  end
  assign tx_pre = tx_sel ^ ctrl.tx_invert;

  always_ff @(posedge aclk) begin
    if (!aresetn) optical_transmit_pin <= 1'b1;
    else if (ctrl.tx_modulation_enable) optical_transmit_pin <= tx_pre | !carrier_low;
    else optical_transmit_pin <= tx_pre;
  end

  assign status = {4'(pending[0]), fifo_mode, uart_rx, active[1], active[0]};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_duty_low_len: assert property ($stable(ctrl.tx_modulation_duty) &&
    car_cnt == low_len - 1'b1 |-> carrier_low ##1
    ($changed(ctrl.tx_modulation_duty) || !carrier_low)) else $error("carrier low length wrong");
  a_rx_digital: assert property (ctrl.rx_pin_digital_select ##1 ctrl.rx_pin_digital_select
    |-> uart_rx && general_digital_pin_one == $past(rx_level[1])) else $error("rx route");
  a_rx_invert: assert property (!ctrl.rx_pin_digital_select |=>
    uart_rx == ($past(rx_level[0]) ^ $past(ctrl.rx_comparator_invert))) else $error("rx inv");
  a_tx_select: assert property (!ctrl.tx_modulation_enable && !ctrl.tx_invert &&
    ctrl.tx_pin_source_select == TX_UART |=> optical_transmit_pin == $past(uart_tx))
    else $error("tx select");
  a_tx_invert: assert property (!ctrl.tx_modulation_enable && ctrl.tx_invert &&
    ctrl.tx_pin_source_select == TX_DIO_TWO |=>
    optical_transmit_pin == !$past(general_digital_pin_two)) else $error("tx invert");
  a_tx_modulate: assert property (ctrl.tx_modulation_enable && !tx_pre |=>
    optical_transmit_pin == !$past(carrier_low)) else $error("modulation");
  a_width_limit: assert property (active[0] && limit_en && !fifo_mode |->
    units[0] < limit) else $error("pulse too wide");
  a_no_limit: assert property (!limit_en && !fifo_mode && active[0] &&
    energy_pulse_request[0] |=> active[0]) else $error("limit not disabled");
  a_fifo_bypass: assert property (!fifo_mode && !active[1] &&
    energy_pulse_request[1] && !req_prev[1] |=>
    active[1] ##1 !reactive_energy_pulse == !ctrl.pulse_polarity_invert) else $error("bypass");
  a_pulse_polarity: assert property (##1 real_energy_pulse ==
    ($past(active[0]) ~^ $past(ctrl.pulse_polarity_invert))) else $error("polarity");
  a_carrier_wrap: assert property (car_cnt == CW'(CARRIER_CYCLES - 1) |=>
    car_cnt == '0) else $error("carrier period");

  c_modulated: cover property (ctrl.tx_modulation_enable && !optical_transmit_pin);
  c_fifo_pulse: cover property (fifo_mode && g_pulse[0].take);
  c_width_cut: cover property (limit_en && active[0] && energy_pulse_request[0] ##1 !active[0]);
endmodule

/* File: test/optical_partner.sv */
// behavioural optical transceiver and pulse counter on the far side of the pins
`timescale 1ns/10ps
module optical_partner (
  // clock
  input wire logic aclk,
  // light seen by the receive photodiode, high is dark
  input wire logic light_level,
  // transmit led line and counter clear
  input wire logic tx_line,
  input wire logic clear,
  // receive pin views
  output logic rx_comparator_in,
  output logic optical_receive_pin,
  // cycles the transmit line spent low since clear
  output int low_cycles
);
  // both pin views follow the light; a real comparator would add its own delay
  assign rx_comparator_in = light_level;
  assign optical_receive_pin = light_level;

  // count led-on cycles, like a pulse counter gating on the low level
  always_ff @(posedge aclk) begin
    if (clear) begin
      low_cycles <= 0;
    end else if (!tx_line) begin
      low_cycles <= low_cycles + 1;
    end
  end
endmodule

/* File: test/testbench.sv */
// self-checking bench for the optical port and pulse output block
`timescale 1ns/10ps
module testbench;
  import optical_pulse_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic uart_tx = 1, pin_two = 0, light = 1, clr = 1;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic [1:0] req = '0, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, uart_rx, pin_one, tx_pin, real_p, react_p;
  logic cmp, dpin, found;
  int lows, miscompares = 0, num_checks = 0;

  // short counts keep the run small: one sample time is 20 cycles
  optical_pulse_port #(.SAMPLE_CYC(20), .CARRIER_CYCLES(16)) i_optical_pulse_port (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rx_comparator_in(cmp),
    .optical_receive_pin(dpin), .uart_rx(uart_rx), .general_digital_pin_one(pin_one),
    .uart_tx(uart_tx), .general_digital_pin_two(pin_two), .energy_pulse_request(req),
    .optical_transmit_pin(tx_pin), .real_energy_pulse(real_p), .reactive_energy_pulse(react_p));

  optical_partner i_optical_partner (.aclk(aclk), .light_level(light), .tx_line(tx_pin),
    .clear(clr), .rx_comparator_in(cmp), .optical_receive_pin(dpin), .low_cycles(lows));

  initial begin
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // write address and data offered together, each released when taken
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic a, w;
    n = 0;
    a = 1;
    w = 1;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while ((a || w) && n < 100) begin
      @(posedge aclk);
      n++;
      if (a && awready) begin
        a = 0;
        awvalid <= 0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 0;
      end
    end
    while (!bvalid && n < 100) begin
      @(posedge aclk);
      n++;
    end
    bready <= 0;
    chk(n < 100, 1);
    chk(bresp, er);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 100);
    arvalid <= 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 100);
    rready <= 0;
    chk(n < 100, 1);
    chk(rdata, {24'h0, ed});
    chk(rresp, er);
  endtask

  task automatic t_regs();
    rd(IDX_MAX_WIDTH, 8'hFF, RESP_OKAY);
    rd(IDX_INTERVAL, 8'h00, RESP_OKAY);
    rd(IDX_TX_CFG, 8'h00, RESP_OKAY);
    rd(IDX_OPT_CFG, 8'h00, RESP_OKAY);
    rd(IDX_PULSE_CFG, 8'h00, RESP_OKAY);
    rd(IDX_STATUS, 8'h04, RESP_OKAY);
    wr(16'h2010, 8'h5A, RESP_SLVERR);
    rd(16'h2010, 8'h00, RESP_SLVERR);
    wr(IDX_TX_CFG, 8'hC3, RESP_OKAY);
    rd(IDX_TX_CFG, 8'hC3, RESP_OKAY);
  endtask

  // every source held opposite to its neighbours, then all flipped
  task automatic t_select();
    logic [3:0] exp;
    for (int k = 0; k < 2; k++) begin
      uart_tx <= k[0];
      pin_two <= !k[0];
      req <= k[0] ? 2'b10 : 2'b01;
      exp = k[0] ? 4'b0101 : 4'b1010;
      for (int s = 0; s < 4; s++) begin
        wr(IDX_TX_CFG, 8'(s << 6), RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk(tx_pin, exp[s]);
        chk({real_p, react_p}, {k[0], !k[0]});
      end
    end
    req <= 2'b00;
  endtask

  // inverted idle-high uart gives a low line that the carrier gates
  task automatic t_modulate();
    wr(IDX_TX_CFG, 8'h00, RESP_OKAY);
    wr(IDX_OPT_CFG, 8'h01, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk(tx_pin, 0);
    // second digital pin is low here, so the inverted pin must be high
    wr(IDX_TX_CFG, 8'h40, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk(tx_pin, 1);
    wr(IDX_OPT_CFG, 8'h03, RESP_OKAY);
    for (int d = 0; d < 5; d++) begin
      if (d == 4) uart_tx <= 0;
      wr(IDX_TX_CFG, 8'(d % 4), RESP_OKAY);
      repeat (4) @(posedge aclk);
      clr <= 1;
      @(posedge aclk);
      clr <= 0;
      repeat (17) @(posedge aclk);
      chk(lows, d == 4 ? 0 : 16 >> (d + 1));
    end
    uart_tx <= 1;
    wr(IDX_OPT_CFG, 8'h00, RESP_OKAY);
  endtask

  task automatic t_receive();
    light <= 0;
    repeat (8) @(posedge aclk);
    chk(uart_rx, 0);
    wr(IDX_OPT_CFG, 8'h10, RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk(uart_rx, 1);
    wr(IDX_OPT_CFG, 8'h30, RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk({uart_rx, pin_one}, 2'b10);
    light <= 1;
    repeat (8) @(posedge aclk);
    chk(pin_one, 1);
    wr(IDX_OPT_CFG, 8'h00, RESP_OKAY);
  endtask

  // a held request is cut after 2N+1 sample times, the first one partial
  task automatic t_width();
    wr(IDX_MAX_WIDTH, 8'h02, RESP_OKAY);
    wr(IDX_TX_CFG, 8'h80, RESP_OKAY);
    clr <= 1;
    @(posedge aclk);
    clr <= 0;
    req <= 2'b01;
    repeat (200) @(posedge aclk);
    req <= 2'b00;
    chk(lows >= 80 && lows <= 102, 1);
    wr(IDX_PULSE_CFG, 8'h40, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk({real_p, react_p}, 2'b00);
    req <= 2'b01;
    repeat (4) @(posedge aclk);
    chk(real_p, 1);
    req <= 2'b00;
    wr(IDX_PULSE_CFG, 8'h00, RESP_OKAY);
    wr(IDX_MAX_WIDTH, 8'hFF, RESP_OKAY);
  endtask

  // paced mode: the queued pulse leaves on a later interval tick
  task automatic t_fifo();
    found = 0;
    wr(IDX_INTERVAL, 8'd81, RESP_OKAY);
    req <= 2'b01;
    for (int n = 0; n < 3400 && !found; n++) begin
      @(posedge aclk);
      if (real_p === 1'b0) found = 1;
    end
    req <= 2'b00;
    chk(found, 1);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    clr <= 0;
    t_regs();
    t_select();
    t_modulate();
    t_receive();
    t_width();
    t_fifo();
    summarize();
  end

  // watchdog sized well above the expected run of under five thousand cycles
  initial begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    summarize();
  end
endmodule
